// ==== logic/dtsr_pkg.sv ====
package dtsr_pkg;

  localparam int SHADOW_COUNT = 16;
  localparam int SHADOW_IDX_W = 4;
  localparam int SHADOW_DATA_W = 16;
  localparam logic [SHADOW_IDX_W-1:0] SHADOW_LAST = 4'hF;

  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COMMAND = 12'h008;
  localparam logic [11:0] ADDR_SHADOW_BASE = 12'h040;
  localparam logic [11:0] ADDR_SHADOW_MASK = 12'hFC0;
  localparam int ADDR_IDX_LSB = 2;

  localparam int CFG_TRIG_LSB = 0;
  localparam int CFG_BRK_LSB = 4;
  localparam int CFG_PROC_BIT = 8;

  localparam int ST_BG_BIT = 0;
  localparam int ST_RESET_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_VALID_BIT = 3;
  localparam int ST_ARMED_BIT = 4;

  localparam int CMD_CAPTURE_BIT = 0;
  localparam int CMD_RESTORE_BIT = 1;
  localparam int CMD_CLEAR_BIT = 2;
  localparam int CMD_BREAK_BIT = 3;

  localparam int SHADOW_DEF_BIT = 31;

  typedef enum logic [1:0] {
    TRIG_FIX_HIGH,
    TRIG_FIX_LOW,
    TRIG_BG_HIGH,
    TRIG_BG_LOW
  } dtsr_trig_mode_t;

  typedef enum logic [1:0] {
    BRK_OFF,
    BRK_RISING,
    BRK_FALLING
  } dtsr_brk_mode_t;

  localparam dtsr_trig_mode_t TRIG_DEFAULT = TRIG_BG_HIGH;
  localparam dtsr_brk_mode_t BRK_DEFAULT = BRK_RISING;

  typedef struct packed {
    logic valid;
    logic write;
    logic [SHADOW_IDX_W-1:0] index;
    logic [SHADOW_DATA_W-1:0] data;
  } dtsr_tgt_req_t;

endpackage : dtsr_pkg

// ==== logic/dtsr_trig_edge.sv ====
`timescale 1ns/1ps
module dtsr_trig_edge
  import dtsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic triggerIn,
  input wire dtsr_brk_mode_t breakMode,
  output logic edgePulse
);

  logic syncA;
  logic syncB;
  logic prevLevel;

  // syncA feeds syncB only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      prevLevel <= 1'b0;
    end else begin
      syncA <= triggerIn;
      syncB <= syncA;
      prevLevel <= syncB;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      edgePulse <= 1'b0;
    end else begin
      unique case (breakMode)
        BRK_RISING: edgePulse <= syncB & ~prevLevel;
        BRK_FALLING: edgePulse <= ~syncB & prevLevel;
        // code 3 is illegal and behaves as off
        default: edgePulse <= 1'b0;
      endcase
    end
  end

endmodule : dtsr_trig_edge

// ==== logic/dtsr_shadow_seq.sv ====
`timescale 1ns/1ps
module dtsr_shadow_seq
  import dtsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic startRestore,
  input wire logic startCapture,
  input wire logic [SHADOW_COUNT-1:0] defined,
  input wire logic [SHADOW_COUNT-1:0][SHADOW_DATA_W-1:0] values,
  input wire logic tgtAck,
  input wire logic [SHADOW_DATA_W-1:0] tgtRdata,
  output dtsr_tgt_req_t tgtReq,
  output logic busy,
  output logic capValid,
  output logic [SHADOW_IDX_W-1:0] capIndex,
  output logic [SHADOW_DATA_W-1:0] capData
);

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ISSUE,
    SEQ_WAIT
  } dtsr_seq_state_t;

  dtsr_seq_state_t state;
  logic isWrite;
  logic [SHADOW_IDX_W-1:0] idx;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= SEQ_IDLE;
      isWrite <= 1'b0;
      idx <= '0;
      busy <= 1'b0;
      tgtReq <= '0;
    end else begin
      unique case (state)
        SEQ_IDLE: begin
          idx <= '0;
          if (startRestore || startCapture) begin
            isWrite <= startRestore;
            busy <= 1'b1;
            state <= SEQ_ISSUE;
          end
        end
        SEQ_ISSUE: begin
          if (isWrite && !defined[idx]) begin
            // undefined entries are skipped, target keeps its value
            if (idx == SHADOW_LAST) begin
              busy <= 1'b0;
              state <= SEQ_IDLE;
            end else begin
              idx <= idx + 1'b1;
            end
          end else begin
            tgtReq.valid <= 1'b1;
            tgtReq.write <= isWrite;
            tgtReq.index <= idx;
            tgtReq.data <= isWrite ? values[idx] : '0;
            state <= SEQ_WAIT;
          end
        end
        SEQ_WAIT: begin
          if (tgtAck) begin
            tgtReq.valid <= 1'b0;
            if (idx == SHADOW_LAST) begin
              busy <= 1'b0;
              state <= SEQ_IDLE;
            end else begin
              idx <= idx + 1'b1;
              state <= SEQ_ISSUE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      capValid <= 1'b0;
      capIndex <= '0;
      capData <= '0;
    end else begin
      capValid <= (state == SEQ_WAIT) && tgtAck && !isWrite;
      if ((state == SEQ_WAIT) && tgtAck) begin
        capIndex <= idx;
        capData <= tgtRdata;
      end
    end
  end

endmodule : dtsr_shadow_seq

// ==== logic/dtsr_top.sv ====
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Operation
// - trigger out: high, low, bg-high, bg-low
// - break input off ignores trigger input
// - rising setting breaks on low-to-high edge
// - falling setting breaks on high-to-low edge
// - plug-in variant locks trigger settings at defaults
// - one shadow entry per target register
// - reset in background then break restores shadows
// - shadow valid only for specific processor type
// - loading shadows never writes the target
module dtsr_top
  import dtsr_pkg::*;
#(
  parameter bit PLUGIN_VARIANT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic triggerIn,
  output logic triggerOut,
  input wire logic targetBackground,
  input wire logic targetReset,
  output logic breakReq,
  output dtsr_tgt_req_t tgtReq,
  input wire logic tgtAck,
  input wire logic [SHADOW_DATA_W-1:0] tgtRdata
);

  dtsr_trig_mode_t trigMode;
  dtsr_brk_mode_t breakMode;
  logic procSpecific;

  logic bgSyncA;
  logic bgSync;
  logic rstSyncA;
  logic rstSync;

  logic [SHADOW_COUNT-1:0][SHADOW_DATA_W-1:0] shadowValue;
  logic [SHADOW_COUNT-1:0] shadowDefined;

  logic edgePulse;
  logic swBreak;
  logic armed;
  logic breakSeen;
  logic restoreFire;
  logic startRestore;
  logic startCapture;
  logic clearDefined;
  logic seqBusy;
  logic capValid;
  logic [SHADOW_IDX_W-1:0] capIndex;
  logic [SHADOW_DATA_W-1:0] capData;

  logic accessDone;
  logic wrAccess;
  logic rdAccess;
  logic isShadow;
  logic [SHADOW_IDX_W-1:0] busIdx;
  logic mapped;
  logic [31:0] next_prdata;
  logic cmdWrite;

  // one-wait slave: pready is raised for exactly one cycle of each access, one cycle after penable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  assign accessDone = psel & penable & pready;
  assign wrAccess = accessDone & pwrite;
  assign rdAccess = psel & penable & ~pready & ~pwrite;
  assign isShadow = (paddr & ADDR_SHADOW_MASK) == ADDR_SHADOW_BASE;
  assign busIdx = paddr[ADDR_IDX_LSB +: SHADOW_IDX_W];
  assign mapped = isShadow || (paddr == ADDR_CONFIG) || (paddr == ADDR_STATUS)
                  || (paddr == ADDR_COMMAND);
  assign cmdWrite = wrAccess && (paddr == ADDR_COMMAND);

  always_comb begin
    next_prdata = '0;
    if (isShadow) begin
      next_prdata[SHADOW_DATA_W-1:0] = shadowValue[busIdx];
      next_prdata[SHADOW_DEF_BIT] = shadowDefined[busIdx];
    end else if (paddr == ADDR_CONFIG) begin
      next_prdata[CFG_TRIG_LSB +: 2] = trigMode;
      next_prdata[CFG_BRK_LSB +: 2] = breakMode;
      next_prdata[CFG_PROC_BIT] = procSpecific;
    end else if (paddr == ADDR_STATUS) begin
      next_prdata[ST_BG_BIT] = bgSync;
      next_prdata[ST_RESET_BIT] = rstSync;
      next_prdata[ST_BUSY_BIT] = seqBusy;
      next_prdata[ST_VALID_BIT] = procSpecific;
      next_prdata[ST_ARMED_BIT] = armed;
    end
  end

  // read data and error are loaded together with pready
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      prdata <= rdAccess ? next_prdata : '0;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trigMode <= TRIG_DEFAULT;
      breakMode <= BRK_DEFAULT;
      procSpecific <= 1'b0;
    end else if (wrAccess && (paddr == ADDR_CONFIG)) begin
      procSpecific <= pwdata[CFG_PROC_BIT];
      if (!PLUGIN_VARIANT) begin
        trigMode <= dtsr_trig_mode_t'(pwdata[CFG_TRIG_LSB +: 2]);
        breakMode <= dtsr_brk_mode_t'(pwdata[CFG_BRK_LSB +: 2]);
      end
    end
  end

  // target status lines are asynchronous pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bgSyncA <= 1'b0;
      bgSync <= 1'b0;
      rstSyncA <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      bgSyncA <= targetBackground;
      bgSync <= bgSyncA;
      rstSyncA <= targetReset;
      rstSync <= rstSyncA;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      triggerOut <= 1'b1;
    end else begin
      unique case (trigMode)
        TRIG_FIX_HIGH: triggerOut <= 1'b1;
        TRIG_FIX_LOW: triggerOut <= 1'b0;
        TRIG_BG_HIGH: triggerOut <= bgSync;
        TRIG_BG_LOW: triggerOut <= ~bgSync;
      endcase
    end
  end

  dtsr_trig_edge u_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .triggerIn(triggerIn),
    .breakMode(breakMode),
    .edgePulse(edgePulse)
  );

  assign swBreak = cmdWrite && pwdata[CMD_BREAK_BIT];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      breakReq <= 1'b0;
    end else begin
      breakReq <= edgePulse | swBreak;
    end
  end

  // a reset taken while running user code drops the arm; the
  // target's own init code is then expected to set the registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      armed <= 1'b0;
      breakSeen <= 1'b0;
    end else begin
      if (rstSync) begin
        armed <= bgSync;
        breakSeen <= 1'b0;
      end else if (startRestore && restoreFire) begin
        armed <= 1'b0;
        breakSeen <= 1'b0;
      end else if (armed && breakReq) begin
        breakSeen <= 1'b1;
      end
    end
  end

  assign restoreFire = armed && breakSeen && bgSync && !rstSync;
  // restore and capture only make sense with a known register layout
  assign startRestore = procSpecific && !seqBusy
                        && (restoreFire || (cmdWrite && pwdata[CMD_RESTORE_BIT]));
  assign startCapture = procSpecific && !seqBusy && !startRestore
                        && cmdWrite && pwdata[CMD_CAPTURE_BIT];
  assign clearDefined = cmdWrite && pwdata[CMD_CLEAR_BIT];

  // capture issues reads only, so the target is never modified
  dtsr_shadow_seq u_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .startRestore(startRestore),
    .startCapture(startCapture),
    .defined(shadowDefined),
    .values(shadowValue),
    .tgtAck(tgtAck),
    .tgtRdata(tgtRdata),
    .tgtReq(tgtReq),
    .busy(seqBusy),
    .capValid(capValid),
    .capIndex(capIndex),
    .capData(capData)
  );

  // one entry per target register; capture beats a same-cycle bus write
  // and any set beats the clear
  for (genvar i = 0; i < SHADOW_COUNT; i++) begin : g_shadow
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        shadowValue[i] <= '0;
        shadowDefined[i] <= 1'b0;
      end else begin
        if (capValid && (capIndex == SHADOW_IDX_W'(i))) begin
          shadowValue[i] <= capData;
          shadowDefined[i] <= 1'b1;
        end else if (wrAccess && isShadow && (busIdx == SHADOW_IDX_W'(i))) begin
          shadowValue[i] <= pwdata[SHADOW_DATA_W-1:0];
          shadowDefined[i] <= 1'b1;
        end else if (clearDefined) begin
          shadowDefined[i] <= 1'b0;
        end
      end
    end
  end

endmodule : dtsr_top

// ==== verif/dtsr_target_model.sv ====
`timescale 1ns/1ps
module dtsr_target_model
  import dtsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slow,
  input wire dtsr_tgt_req_t tgtReq,
  output logic tgtAck,
  output logic [SHADOW_DATA_W-1:0] tgtRdata
);
  logic [SHADOW_COUNT-1:0][SHADOW_DATA_W-1:0] regs;
  logic [1:0] cnt;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tgtAck <= 1'b0;
      cnt <= 2'h0;
      tgtRdata <= 16'hA5A5;
      for (int i = 0; i < SHADOW_COUNT; i++) regs[i] <= 16'(16'h1000 + i);
    end else if (tgtReq.valid && !tgtAck && cnt >= (slow ? 2'h2 : 2'h0)) begin
      tgtAck <= 1'b1;
      cnt <= 2'h0;
      tgtRdata <= regs[tgtReq.index];
      if (tgtReq.write) regs[tgtReq.index] <= tgtReq.data;
    end else begin
      tgtAck <= 1'b0;
      // stale data toggles so a late sample cannot look right
      tgtRdata <= ~tgtRdata;
      if (tgtReq.valid && !tgtAck) cnt <= cnt + 2'h1;
    end
  end
endmodule : dtsr_target_model

// ==== verif/dtsr_chk.sv ====
`timescale 1ns/1ps
module dtsr_chk
  import dtsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic triggerIn,
  input wire logic triggerOut,
  input wire logic breakReq,
  input wire dtsr_tgt_req_t tgtReq,
  input wire logic tgtAck
);
  logic [1:0] trigM;
  logic [1:0] brkM;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trigM <= 2'h2;
      brkM <= 2'h1;
    end else if (psel && penable && pready && pwrite && paddr == ADDR_CONFIG) begin
      trigM <= pwdata[1:0];
      brkM <= pwdata[5:4];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_brk; ##4 breakReq; endsequence
  a_ready_after_access: assert property (s_access |=> pready)
    else $error("access not answered");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_break_one_cycle: assert property (breakReq |=> !breakReq)
    else $error("break pulse too long");
  a_rise_break: assert property (brkM == 2'h1 && $rose(triggerIn) |-> s_brk)
    else $error("no break on rising edge");
  a_fall_break: assert property (brkM == 2'h2 && $fell(triggerIn) |-> s_brk)
    else $error("no break on falling edge");
  a_fixed_low: assert property ((trigM == 2'h1) [*4] |-> !triggerOut)
    else $error("trigger out not low");
  a_req_hold: assert property (tgtReq.valid && !tgtAck |=> tgtReq.valid && $stable(tgtReq))
    else $error("target request changed");
  a_req_drop: assert property (tgtReq.valid && tgtAck |=> !tgtReq.valid)
    else $error("target request not dropped");
endmodule : dtsr_chk

bind dtsr_top dtsr_chk u_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .triggerIn(triggerIn), .triggerOut(triggerOut), .breakReq(breakReq), .tgtReq(tgtReq),
  .tgtAck(tgtAck));

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb
  import dtsr_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, triggerOut, breakReq, tgtAck, err, slow = 1'b0;
  logic triggerIn = 1'b0, targetBackground = 1'b0, targetReset = 1'b0;
  dtsr_tgt_req_t tgtReq;
  logic [SHADOW_DATA_W-1:0] tgtRdata;
  int n_mismatch = 0, checks = 0, c;
  always #12.5 sys_clk = ~sys_clk;
  dtsr_top dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .triggerIn(triggerIn), .triggerOut(triggerOut),
    .targetBackground(targetBackground), .targetReset(targetReset), .breakReq(breakReq),
    .tgtReq(tgtReq), .tgtAck(tgtAck), .tgtRdata(tgtRdata));
  dtsr_target_model tgt (.sys_clk(sys_clk), .rst(rst), .slow(slow), .tgtReq(tgtReq),
    .tgtAck(tgtAck), .tgtRdata(tgtRdata));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 50);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge keeps a following call from re-driving psel in this step
    @(posedge sys_clk);
  endtask : apb
  task automatic pulses(input logic v, output int n);
    triggerIn <= v;
    n = 0;
    repeat (8) begin @(posedge sys_clk); if (breakReq === 1'b1) n++; end
  endtask : pulses
  task automatic settle();
    int k = 0;
    cyc(10);
    do begin apb(1'b0, ADDR_STATUS, 32'h0); k++; end while (r[ST_BUSY_BIT] !== 1'b0 && k < 100);
  endtask : settle
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    cyc(20000);
    n_mismatch++;
    test_done();
  end
  initial begin
    cyc(10);
    rst <= 1'b0;
    apb(1'b0, ADDR_CONFIG, 32'h0); chk(r, 32'h12);
    apb(1'b0, 12'h00C, 32'h0); chk(32'(err), 32'h1);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      targetBackground <= m[2];
      apb(1'b1, ADDR_CONFIG, 32'(32'h10 | m[1:0]));
      cyc(6);
      chk(32'(triggerOut), 32'(m[1] ? m[2] ^ m[0] : !m[0]));
    end
    $display("test trigger out done");
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, ADDR_CONFIG, 32'(32'h2 | (b << 4)));
      pulses(1'b1, c); chk(32'(c), 32'(b == 1));
      pulses(1'b0, c); chk(32'(c), 32'(b == 2));
    end
    $display("test break in done");
    apb(1'b1, ADDR_CONFIG, 32'h12);
    apb(1'b1, ADDR_SHADOW_BASE + 12'h00C, 32'h1234);
    apb(1'b1, ADDR_COMMAND, 32'h1);
    cyc(40);
    apb(1'b0, ADDR_SHADOW_BASE + 12'h00C, 32'h0); chk(r, 32'h80001234);
    chk(32'(tgt.regs[3]), 32'h1003);
    slow <= 1'b1;
    apb(1'b1, ADDR_CONFIG, 32'h112);
    apb(1'b1, ADDR_COMMAND, 32'h1);
    settle();
    apb(1'b0, ADDR_SHADOW_BASE + 12'h03C, 32'h0); chk(r, 32'h8000100F);
    apb(1'b0, ADDR_SHADOW_BASE + 12'h00C, 32'h0); chk(r, 32'h80001003);
    $display("test capture done");
    slow <= 1'b0;
    apb(1'b1, ADDR_COMMAND, 32'h4);
    apb(1'b1, ADDR_SHADOW_BASE + 12'h008, 32'hBEEF);
    apb(1'b1, ADDR_SHADOW_BASE + 12'h01C, 32'h0042);
    chk(32'(tgt.regs[2]), 32'h1002);
    targetBackground <= 1'b1;
    targetReset <= 1'b1;
    cyc(6);
    targetReset <= 1'b0;
    cyc(6);
    apb(1'b1, ADDR_COMMAND, 32'h8);
    settle();
    chk(32'(tgt.regs[2]), 32'hBEEF);
    chk(32'(tgt.regs[7]), 32'h0042);
    chk(32'(tgt.regs[5]), 32'h1005);
    apb(1'b0, ADDR_STATUS, 32'h0); chk(r, 32'h9);
    $display("test restore done");
    test_done();
  end
endmodule : tb
